/* File: wdog_pkg.sv */
// watchdog constants, states and command codes
`default_nettype none
package wdog_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned BAUD = 9600;
    localparam int unsigned REF_HZ = 32768;
    localparam int unsigned SEC_S = 1;
    localparam int unsigned LOCK_MS = 250;
    localparam int unsigned PULSE_MS = 1;
    localparam int unsigned MS_PER_S = 1000;
    localparam logic [15:0] BIT_CYCLES = 16'(CLK_HZ / BAUD);
    localparam logic [15:0] SEC_REF_EDGES = 16'(REF_HZ * SEC_S);
    localparam logic [15:0] LOCK_REF_EDGES = 16'(REF_HZ * LOCK_MS / MS_PER_S);
    localparam logic [23:0] PULSE_CYCLES = 24'(CLK_HZ / MS_PER_S * PULSE_MS);
    // ----------------------------------------
    // interval and commands
    // ----------------------------------------
    localparam logic [2:0] INTERVAL_MIN = 3'h1;
    localparam logic [2:0] INTERVAL_RESET = 3'h5;
    localparam logic [7:0] CMD_SEL_MIN = 8'h01;
    localparam logic [7:0] CMD_SEL_MAX = 8'h05;
    localparam logic [7:0] CMD_FEED = 8'h06;
    localparam logic [7:0] CMD_HOST_RESET = 8'h07;
    // ----------------------------------------
    // pin synchroniser lanes
    // ----------------------------------------
    localparam int unsigned IDX_REF = 0;
    localparam int unsigned IDX_FEED = 1;
    localparam int unsigned IDX_MANUAL_RESET_IN = 2;
    localparam int unsigned IDX_RX = 3;
    localparam logic [3:0] SYNC_RESET = 4'hE;
    // ----------------------------------------
    // states
    // ----------------------------------------
    typedef enum logic [1:0] {P_IDLE = 2'b01, P_LOW = 2'b10} pulse_state_t;
    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } rx_state_t;
endpackage
`default_nettype wire

/* File: serial_rx.sv */
// serial byte receiver, eight data bits, no parity, one stop bit
`timescale 1ns/1ps
`default_nettype none
module serial_rx #(
    parameter logic [15:0] BIT_CYCLES = wdog_pkg::BIT_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic rx_i,
    output logic [7:0] data_o,
    output logic valid_o
);
    localparam logic [15:0] HALF_CYCLES = BIT_CYCLES >> 1;
    localparam logic [2:0] LAST_BIT = 3'h7;

    wdog_pkg::rx_state_t state_reg;
    logic [15:0] cnt_reg;
    logic [2:0] bit_reg;
    logic [7:0] shift_reg;
    logic bit_end;

    assign bit_end = (cnt_reg == BIT_CYCLES - 16'h0001);

    // ----------------------------------------
    // frame sequencer
    // ----------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= wdog_pkg::RX_IDLE;
            cnt_reg <= 16'h0000;
            bit_reg <= 3'h0;
            shift_reg <= 8'h00;
            data_o <= 8'h00;
            valid_o <= 1'b0;
        end else begin
            valid_o <= 1'b0;
            cnt_reg <= cnt_reg + 16'h0001;
            unique case (state_reg)
                wdog_pkg::RX_IDLE: begin
                    cnt_reg <= 16'h0000;
                    if (!rx_i) begin
                        state_reg <= wdog_pkg::RX_START;
                    end
                end
                wdog_pkg::RX_START: begin
                    if (cnt_reg == HALF_CYCLES - 16'h0001) begin
                        cnt_reg <= 16'h0000;
                        bit_reg <= 3'h0;
                        state_reg <= rx_i ? wdog_pkg::RX_IDLE : wdog_pkg::RX_DATA;
                    end
                end
                wdog_pkg::RX_DATA: begin
                    if (bit_end) begin
                        cnt_reg <= 16'h0000;
                        shift_reg <= {rx_i, shift_reg[7:1]};
                        bit_reg <= bit_reg + 3'h1;
                        if (bit_reg == LAST_BIT) begin
                            state_reg <= wdog_pkg::RX_STOP;
                        end
                    end
                end
                wdog_pkg::RX_STOP: begin
                    if (bit_end) begin
                        state_reg <= wdog_pkg::RX_IDLE;
                        if (rx_i) begin
                            data_o <= shift_reg;
                            valid_o <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: external_watchdog_uart.sv */
// external watchdog top: feed, manual reset, serial commands, host reset pulse
`timescale 1ns/1ps
`default_nettype none
module external_watchdog_uart #(
    parameter logic [15:0] SEC_EDGES = wdog_pkg::SEC_REF_EDGES,
    parameter logic [15:0] LOCK_EDGES = wdog_pkg::LOCK_REF_EDGES,
    parameter logic [23:0] PULSE_CYCLES = wdog_pkg::PULSE_CYCLES,
    parameter logic [15:0] BIT_CYCLES = wdog_pkg::BIT_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic reference_oscillator_i,
    input wire logic feed_in_i,
    input wire logic manual_reset_in_i,
    input wire logic serial_rx_i,
    output logic host_reset_out_n_o,
    output logic reset_status_o
);
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] last_reg;
    logic ref_rise, feed_fall, manual_reset_in_fall;
    logic lock_reg;
    logic [15:0] lock_cnt_reg;
    logic feed_ok, manual_reset_in_ok;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic sel_evt, feed_evt, manual_evt;
    logic [15:0] div_cnt_reg;
    logic [2:0] sec_cnt_reg;
    logic [2:0] interval_reg;
    logic sec_tick, timeout, restart;
    wdog_pkg::pulse_state_t pstate_reg;
    logic [23:0] pulse_cnt_reg;
    logic pulse_manual_reg;
    logic pulse_end;

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    function automatic logic cmd_is_sel(input logic [7:0] b);
        return (b >= wdog_pkg::CMD_SEL_MIN) && (b <= wdog_pkg::CMD_SEL_MAX);
    endfunction

    // ----------------------------------------
    // pin synchronisers and edge detect
    // ----------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_reg <= wdog_pkg::SYNC_RESET;
            sync2_reg <= wdog_pkg::SYNC_RESET;
            last_reg <= wdog_pkg::SYNC_RESET;
        end else begin
            sync1_reg <= {serial_rx_i, manual_reset_in_i, feed_in_i, reference_oscillator_i};
            sync2_reg <= sync1_reg;
            last_reg <= sync2_reg;
        end
    end

    assign ref_rise = sync2_reg[wdog_pkg::IDX_REF] && !last_reg[wdog_pkg::IDX_REF];
    assign feed_fall = !sync2_reg[wdog_pkg::IDX_FEED] && last_reg[wdog_pkg::IDX_FEED];
    assign manual_reset_in_fall = !sync2_reg[wdog_pkg::IDX_MANUAL_RESET_IN] && last_reg[wdog_pkg::IDX_MANUAL_RESET_IN];

    // ----------------------------------------
    // input lockout
    // ----------------------------------------
    assign feed_ok = feed_fall && !lock_reg;
    assign manual_reset_in_ok = manual_reset_in_fall && !lock_reg;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            lock_reg <= 1'b0;
            lock_cnt_reg <= 16'h0000;
        end else if (feed_ok || manual_reset_in_ok) begin
            lock_reg <= 1'b1;
            lock_cnt_reg <= 16'h0000;
        end else if (lock_reg && ref_rise) begin
            if (lock_cnt_reg == LOCK_EDGES - 16'h0001) begin
                lock_reg <= 1'b0;
            end
            lock_cnt_reg <= lock_cnt_reg + 16'h0001;
        end
    end

    // ----------------------------------------
    // serial command receiver
    // ----------------------------------------
    serial_rx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_rx (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .rx_i(sync2_reg[wdog_pkg::IDX_RX]),
        .data_o(rx_byte),
        .valid_o(rx_valid)
    );

    assign sel_evt = rx_valid && cmd_is_sel(rx_byte);
    assign feed_evt = feed_ok || (rx_valid && rx_byte == wdog_pkg::CMD_FEED);
    assign manual_evt = manual_reset_in_ok || (rx_valid && rx_byte == wdog_pkg::CMD_HOST_RESET);

    // ----------------------------------------
    // interval select
    // ----------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            interval_reg <= wdog_pkg::INTERVAL_RESET;
        end else if (sel_evt) begin
            interval_reg <= rx_byte[2:0];
        end
    end

    // ----------------------------------------
    // one-second tick and timeout count
    // ----------------------------------------
    assign sec_tick = ref_rise && (div_cnt_reg == SEC_EDGES - 16'h0001);
    assign timeout = sec_tick && (3'(sec_cnt_reg + 3'h1) == interval_reg);
    assign restart = feed_evt || manual_evt || sel_evt || timeout;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt_reg <= 16'h0000;
        end else if (restart) begin
            div_cnt_reg <= 16'h0000;
        end else if (sec_tick) begin
            div_cnt_reg <= 16'h0000;
        end else if (ref_rise) begin
            div_cnt_reg <= div_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sec_cnt_reg <= 3'h0;
        end else if (restart) begin
            sec_cnt_reg <= 3'h0;
        end else if (sec_tick) begin
            sec_cnt_reg <= sec_cnt_reg + 3'h1;
        end
    end

    // ----------------------------------------
    // host reset pulse
    // ----------------------------------------
    assign pulse_end = (pstate_reg == wdog_pkg::P_LOW) &&
        (pulse_cnt_reg == PULSE_CYCLES - 24'h000001);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pstate_reg <= wdog_pkg::P_IDLE;
            pulse_cnt_reg <= 24'h000000;
            pulse_manual_reg <= 1'b0;
            host_reset_out_n_o <= 1'b1;
        end else begin
            unique case (pstate_reg)
                wdog_pkg::P_IDLE: begin
                    pulse_cnt_reg <= 24'h000000;
                    if (timeout || manual_evt) begin
                        pstate_reg <= wdog_pkg::P_LOW;
                        pulse_manual_reg <= !timeout;
                        host_reset_out_n_o <= 1'b0;
                    end
                end
                wdog_pkg::P_LOW: begin
                    pulse_cnt_reg <= pulse_cnt_reg + 24'h000001;
                    if (pulse_end) begin
                        pstate_reg <= wdog_pkg::P_IDLE;
                        host_reset_out_n_o <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // reset status
    // ----------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            reset_status_o <= 1'b0;
        end else if (timeout) begin
            reset_status_o <= 1'b1;
        end else if (feed_evt) begin
            reset_status_o <= 1'b0;
        end else if (manual_evt && pstate_reg == wdog_pkg::P_IDLE) begin
            reset_status_o <= 1'b1;
        end else if (pulse_end && pulse_manual_reg) begin
            reset_status_o <= 1'b0;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_pulse_start;
        host_reset_out_n_o ##1 !host_reset_out_n_o;
    endsequence

    sequence s_count_cleared;
        ##1 (sec_cnt_reg == 3'h0 && div_cnt_reg == 16'h0000);
    endsequence

    a_interval_range: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        interval_reg >= wdog_pkg::INTERVAL_MIN && interval_reg <= wdog_pkg::INTERVAL_RESET)
        else $error("interval out of range");

    a_manual_pulse: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (manual_reset_in_ok && pstate_reg == wdog_pkg::P_IDLE) |-> s_pulse_start and s_count_cleared)
        else $error("manual reset did not pulse host");

    a_pulse_length: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        $rose(host_reset_out_n_o) |-> $past(pulse_cnt_reg) == PULSE_CYCLES - 24'h000001)
        else $error("host reset pulse length wrong");

    a_feed_restart: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        feed_evt |-> s_count_cleared)
        else $error("feed did not restart count");

    a_lockout_edge: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (feed_ok || manual_reset_in_ok) |=> lock_reg && !feed_ok && !manual_reset_in_ok)
        else $error("lockout not engaged");

    a_cmd_select: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        sel_evt |=> interval_reg == $past(rx_byte[2:0]) && sec_cnt_reg == 3'h0)
        else $error("interval command not applied");

    a_bad_cmd: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (rx_valid && (rx_byte == 8'h00 || rx_byte > wdog_pkg::CMD_HOST_RESET) &&
        !feed_ok && !manual_reset_in_ok && !sec_tick && !pulse_end)
        |=> $stable(interval_reg) && $stable(host_reset_out_n_o) && $stable(sec_cnt_reg))
        else $error("invalid command had effect");

    a_timeout_pulse: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (timeout && pstate_reg == wdog_pkg::P_IDLE) |-> s_pulse_start)
        else $error("timeout did not pulse host");

    a_status_set: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        timeout |=> reset_status_o ##1 (reset_status_o || $past(feed_evt)))
        else $error("status not raised on timeout");

    a_status_clear: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (feed_evt && !timeout) |=> !reset_status_o)
        else $error("status not cleared on feed");
endmodule
`default_nettype wire

/* File: host_model.sv */
// host side model: feed pin, manual reset pin and serial command line
`timescale 1ns/1ps
`default_nettype none
module host_model #(
    parameter int BIT_CYC = 16
) (
    input wire logic mclk_i,
    output logic feed_o,
    output logic manual_o,
    output logic tx_o
);
    // ----------------------------------------
    // pins idle high
    // ----------------------------------------
    initial begin
        feed_o = 1'b1;
        manual_o = 1'b1;
        tx_o = 1'b1;
    end
    // ----------------------------------------
    // falling edge on feed or manual pin
    // ----------------------------------------
    task automatic pulse(input bit man);
        @(negedge mclk_i);
        if (man) begin
            manual_o = 1'b0;
        end else begin
            feed_o = 1'b0;
        end
        repeat (8) @(negedge mclk_i);
        feed_o = 1'b1;
        manual_o = 1'b1;
    endtask
    // ----------------------------------------
    // one byte, start, eight bits lsb first, stop
    // ----------------------------------------
    task automatic send(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge mclk_i);
            tx_o = frame[i];
            repeat (BIT_CYC - 1) @(negedge mclk_i);
        end
    endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the external watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ----------------------------------------
    // clocks, pins, counters
    // ----------------------------------------
    localparam int SEC = 16 * 40;
    logic mclk;
    logic rst;
    logic ref_osc;
    logic feed;
    logic manual;
    logic rx;
    logic host_n;
    logic status;
    logic [7:0] cmd;
    bit man;
    int lows;
    int fails;
    int compares;
    int n;
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        ref_osc = 1'b0;
        forever #80 ref_osc = ~ref_osc;
    end
    always @(posedge mclk) if (host_n === 1'b0) lows <= lows + 1;
    host_model #(.BIT_CYC(16)) i_host (
        .mclk_i(mclk),
        .feed_o(feed),
        .manual_o(manual),
        .tx_o(rx)
    );
    external_watchdog_uart #(
        .SEC_EDGES(16'h0010),
        .LOCK_EDGES(16'h0004),
        .PULSE_CYCLES(24'h000014),
        .BIT_CYCLES(16'h0010)
    ) i_dut (
        .mclk_i(mclk),
        .rst_i(rst),
        .reference_oscillator_i(ref_osc),
        .feed_in_i(feed),
        .manual_reset_in_i(manual),
        .serial_rx_i(rx),
        .host_reset_out_n_o(host_n),
        .reset_status_o(status)
    );
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic near(input int v, input int e);
        check((v > e - 70 && v < e + 70) ? e : v, e);
    endtask
    task automatic wait_low(output int c);
        c = 0;
        while (host_n !== 1'b0 && c < 8000) begin
            @(posedge mclk);
            #1;
            c++;
        end
    endtask
    task automatic low_len(output int c);
        c = 0;
        while (host_n === 1'b0 && c < 100) begin
            @(posedge mclk);
            #1;
            c++;
        end
    endtask
    task automatic idle(input int c);
        repeat (c) @(negedge mclk);
    endtask
    task automatic stop_test();
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_default();
        check(host_n, 1'b1);
        check(status, 1'b0);
        wait_low(n);
        near(n, 5 * SEC - 20);
        check(status, 1'b1);
        low_len(n);
        check(n, 20);
        wait_low(n);
        near(n, 5 * SEC - 20);
        low_len(n);
    endtask
    task automatic t_feed();
        int base;
        man = 1'b0;
        i_host.pulse(man);
        check(status, 1'b0);
        base = lows;
        repeat (2) begin
            idle(4 * SEC);
            i_host.pulse(man);
        end
        idle(4 * SEC);
        check(lows - base, 0);
    endtask
    task automatic t_lock();
        int base;
        man = 1'b1;
        i_host.pulse(man);
        check(host_n, 1'b0);
        check(status, 1'b1);
        low_len(n);
        check(status, 1'b0);
        base = lows;
        i_host.pulse(man);
        idle(60);
        check(lows - base, 0);
        idle(200);
        i_host.pulse(man);
        check(host_n, 1'b0);
        low_len(n);
        wait_low(n);
        near(n, 5 * SEC - 40);
    endtask
    task automatic t_cmds();
        low_len(n);
        for (int v = 1; v <= 5; v++) begin
            i_host.send(8'(v));
            wait_low(n);
            near(n, v * SEC - 20);
            low_len(n);
        end
    endtask
    task automatic t_codes();
        logic [7:0] bad [3] = '{8'h00, 8'h08, 8'hFF};
        cmd = 8'h01;
        i_host.send(cmd);
        foreach (bad[i]) i_host.send(bad[i]);
        wait_low(n);
        near(n, SEC - 20 - 480);
        low_len(n);
        cmd = 8'h06;
        i_host.send(cmd);
        check(status, 1'b0);
        cmd = 8'h07;
        i_host.send(cmd);
        check(host_n, 1'b0);
        check(status, 1'b1);
        low_len(n);
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        fails = 0;
        compares = 0;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        t_default();
        t_feed();
        t_lock();
        t_cmds();
        t_codes();
        stop_test();
    end
    initial begin
        #240000;
        fails++;
        stop_test();
    end
endmodule
`default_nettype wire
